//--- rtl/pmt_cpu_end.sv
// Core end: fetch and table requests, serial programmer, debug adapter pins
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_cpu_end
    import pmt_pkg::*;
#(
    parameter int PROG_HALF = `PMT_PROG_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Link to the code store end
    pmt_if.cpu bus,
    // Fetch
    input wire logic usr_fetch_next_i,
    input wire logic usr_jump_i,
    input wire logic [9:0] usr_jump_addr_i,
    output logic [13:0] usr_instr_o,
    output logic [9:0] usr_instr_addr_o,
    output logic usr_instr_valid_o,
    output logic usr_stall_o,
    // Table read and interrupts
    input wire logic usr_tab_req_i,
    input wire logic usr_tab_last_i,
    input wire logic [7:0] usr_tab_dest_i,
    input wire logic usr_in_isr_i,
    input wire logic usr_irq_req_i,
    output logic usr_irq_take_o,
    output logic usr_tab_done_o,
    output logic [7:0] usr_tab_low_o,
    output logic [7:0] usr_tab_dest_o,
    // Special registers
    input wire logic usr_sfr_wr_i,
    input wire pmt_sfr_sel_t usr_sfr_sel_i,
    input wire logic [7:0] usr_sfr_wdata_i,
    output logic [7:0] usr_ptr_lo_o,
    output logic [7:0] usr_ptr_hi_o,
    output logic [7:0] usr_table_high_o,
    // Serial programmer
    input wire logic usr_prog_start_i,
    input wire logic usr_prog_write_i,
    input wire logic [9:0] usr_prog_addr_i,
    input wire logic [13:0] usr_prog_data_i,
    output logic usr_prog_busy_o,
    output logic usr_prog_done_o,
    output logic [13:0] usr_prog_rdata_o,
    // Debug adapter
    input wire logic usr_dbg_clk_i,
    input wire logic usr_dbg_dat_i,
    input wire logic usr_dbg_oe_i,
    output logic usr_dbg_dat_o
);
    logic [1:0] sync1_reg, sync1_next;
    logic [1:0] sync2_reg, sync2_next;
    logic hold_reg, hold_next;
    logic main_tab;
    pmt_pg_state_t st_reg, st_next;
    logic [7:0] div_reg, div_next;
    logic [4:0] bit_reg, bit_next;
    logic [24:0] sh_reg, sh_next;
    logic [13:0] rdata_reg, rdata_next;
    logic wr_reg, wr_next;
    logic en_reg, en_next;
    logic clk_reg, clk_next;
    logic done_reg, done_next;
    logic half_end;

    // Pin inputs pass two flip-flops
    always_comb begin
        sync1_next = {bus.debug_serial_data, bus.prog_serial_data};
        sync2_next = sync1_reg;
    end

    // Interrupts held off while a main-routine table read is open
    assign main_tab = usr_tab_req_i && !usr_in_isr_i;
    always_comb begin
        hold_next = hold_reg;
        if (main_tab) begin
            hold_next = 1'b1;
        end else if (bus.tab_done) begin
            hold_next = 1'b0;
        end
    end
    assign usr_irq_take_o = usr_irq_req_i && !hold_reg && !main_tab;

    // Programmer: frame of command, address and data bits
    assign half_end = (div_reg == 8'(PROG_HALF - 1));
    always_comb begin
        st_next = st_reg;
        div_next = div_reg + 8'h01;
        bit_next = bit_reg;
        sh_next = sh_reg;
        rdata_next = rdata_reg;
        wr_next = wr_reg;
        en_next = en_reg;
        clk_next = clk_reg;
        done_next = 1'b0;
        case (st_reg)
            PMT_PG_IDLE: begin
                div_next = 8'h00;
                if (usr_prog_start_i) begin
                    sh_next = {usr_prog_write_i, usr_prog_addr_i, usr_prog_data_i};
                    wr_next = usr_prog_write_i;
                    bit_next = 5'h00;
                    en_next = 1'b1;
                    st_next = PMT_PG_LOW;
                end
            end
            PMT_PG_LOW: begin
                if (half_end) begin
                    div_next = 8'h00;
                    clk_next = 1'b1;
                    st_next = PMT_PG_HIGH;
                    if (!wr_reg && bit_reg >= `PMT_HDR_BITS) begin
                        rdata_next = {rdata_reg[12:0], sync2_reg[0]};
                    end
                end
            end
            PMT_PG_HIGH: begin
                if (half_end) begin
                    div_next = 8'h00;
                    clk_next = 1'b0;
                    sh_next = {sh_reg[23:0], 1'b0};
                    bit_next = bit_reg + 5'h01;
                    st_next = (bit_reg == `PMT_FRAME_BITS - 5'h01) ? PMT_PG_GAP : PMT_PG_LOW;
                end
            end
            PMT_PG_GAP: begin
                if (half_end) begin
                    en_next = 1'b0;
                    done_next = 1'b1;
                    st_next = PMT_PG_IDLE;
                end
            end
            default: begin
                st_next = PMT_PG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 2'h3;
            sync2_reg <= 2'h3;
            hold_reg <= 1'b0;
            st_reg <= PMT_PG_IDLE;
            div_reg <= 8'h00;
            bit_reg <= 5'h00;
            sh_reg <= 25'h0000000;
            rdata_reg <= 14'h0000;
            wr_reg <= 1'b0;
            en_reg <= 1'b0;
            clk_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            hold_reg <= hold_next;
            st_reg <= st_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            rdata_reg <= rdata_next;
            wr_reg <= wr_next;
            en_reg <= en_next;
            clk_reg <= clk_next;
            done_reg <= done_next;
        end
    end

    // Drive the programming pins only inside a frame
    assign bus.prog_en = en_reg;
    assign bus.prog_serial_clock = clk_reg;
    assign bus.prog_dat_h = sh_reg[24];
    assign bus.prog_oe_h = (st_reg == PMT_PG_LOW || st_reg == PMT_PG_HIGH) &&
                           (bit_reg < `PMT_HDR_BITS || wr_reg);
    assign usr_prog_busy_o = (st_reg != PMT_PG_IDLE);
    assign usr_prog_done_o = done_reg;
    assign usr_prog_rdata_o = rdata_reg;

    // Debug adapter pins
    assign bus.debug_serial_clock = usr_dbg_clk_i;
    assign bus.dbg_dat_h = usr_dbg_dat_i;
    assign bus.dbg_oe_h = usr_dbg_oe_i;
    assign usr_dbg_dat_o = sync2_reg[1];

    // Core requests and answers
    assign bus.fetch_next = usr_fetch_next_i;
    assign bus.jump = usr_jump_i;
    assign bus.jump_addr = usr_jump_addr_i;
    assign bus.tab_req = usr_tab_req_i;
    assign bus.tab_last = usr_tab_last_i;
    assign bus.tab_dest = usr_tab_dest_i;
    assign bus.sfr_wr = usr_sfr_wr_i;
    assign bus.sfr_sel = usr_sfr_sel_i;
    assign bus.sfr_wdata = usr_sfr_wdata_i;
    assign usr_instr_o = bus.instr;
    assign usr_instr_addr_o = bus.instr_addr;
    assign usr_instr_valid_o = bus.instr_valid;
    assign usr_stall_o = bus.stall;
    assign usr_tab_done_o = bus.tab_done;
    assign usr_tab_low_o = bus.tab_low;
    assign usr_tab_dest_o = bus.tab_dest_out;
    assign usr_ptr_lo_o = bus.ptr_lo;
    assign usr_ptr_hi_o = bus.ptr_hi;
    assign usr_table_high_o = bus.table_high_latch;
endmodule

//--- rtl/pmt_dev_end.sv
// Code store end: program memory, table read, serial programming, debug pins
// Behaviour
// - Code store holds 1K words of 14 bits
// - Fetching starts at address 000H after reset
// - Table address from pointer low and high
// - Low byte goes to operand destination
// - Every table read reloads table-high latch
// - Latch bits without code bits read zero
// - Latch ignores software writes
// - Table instructions take two cycles
// - Last-page variant uses 300H page, low pointer
// - Software avoids table reads in interrupt routines
// - Table data reached by table pointer only
// - Serial programming over one data, one clock
// - Only programmer drives programming clock and enable
// - Debug uses one data pin, one clock
// - Emulation variant silences shared pin functions
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_dev_end
    import pmt_pkg::*;
#(
    parameter bit EMULATION = 1'b1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Link to the core end
    pmt_if.dev bus,
    // Functions shared with the debug pins
    input wire logic shared_dat_out_i,
    input wire logic shared_dat_oe_i,
    output logic [1:0] shared_in_o,
    // Status
    output logic prog_active_o
);
    logic [13:0] mem [0:`PMT_MEM_DEPTH-1];
    logic [4:0] sync1_reg, sync1_next;
    logic [4:0] sync2_reg, sync2_next;
    logic clk_prev_reg, clk_prev_next;
    logic en, rise, fall, pin_bit;
    logic [4:0] cnt_reg, cnt_next;
    logic [24:0] sh_reg, sh_next;
    logic [24:0] sh_shift;
    logic [9:0] paddr_reg, paddr_next;
    logic [13:0] out_reg, out_next;
    logic dout_reg, dout_next;
    logic oe_reg, oe_next;
    logic rd_reg, rd_next;
    logic wr_reg, wr_next;
    logic load_reg, load_next;
    logic rd_start;
    logic [9:0] pc_reg, pc_next;
    logic [13:0] rd_data_reg;
    logic [9:0] rd_addr;
    pmt_src_t src_reg, src_next;
    logic [7:0] dest_reg, dest_next;
    logic stall, take_tab;
    logic [7:0] ptr_lo_reg, ptr_lo_next;
    logic [1:0] ptr_hi_reg, ptr_hi_next;
    logic [7:0] latch_reg, latch_next;

    function automatic logic [9:0] tab_addr(input logic last, input logic [1:0] hi,
                                            input logic [7:0] lo);
        logic [9:0] base;
        base = `PMT_LAST_PAGE_BASE;
        if (last) begin
            tab_addr = {base[9:8], lo};
        end else begin
            tab_addr = {hi, lo};
        end
    endfunction

    // Two-stage synchronisers for all pin inputs
    always_comb begin
        sync1_next = {bus.debug_serial_data, bus.debug_serial_clock, bus.prog_serial_data,
                      bus.prog_serial_clock, bus.prog_en};
        sync2_next = sync1_reg;
        clk_prev_next = sync2_reg[1];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            clk_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            clk_prev_reg <= clk_prev_next;
        end
    end

    assign en = sync2_reg[0];
    assign rise = sync2_reg[1] & ~clk_prev_reg;
    assign fall = ~sync2_reg[1] & clk_prev_reg;
    assign pin_bit = sync2_reg[2];
    assign sh_shift = {sh_reg[23:0], pin_bit};

    // Serial programming frame: command, address, then data in or out
    always_comb begin
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        paddr_next = paddr_reg;
        out_next = out_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        rd_next = rd_reg;
        wr_next = 1'b0;
        rd_start = 1'b0;
        if (!en) begin
            cnt_next = 5'h00;
            oe_next = 1'b0;
            rd_next = 1'b0;
        end else begin
            if (rise && cnt_reg < `PMT_FRAME_BITS) begin
                if (cnt_reg < `PMT_HDR_BITS || !rd_reg) begin
                    sh_next = sh_shift;
                end
                cnt_next = cnt_reg + 5'h01;
                if (cnt_reg == `PMT_HDR_BITS - 5'h01) begin
                    rd_next = ~sh_shift[`PMT_CMD_BIT];
                    rd_start = ~sh_shift[`PMT_CMD_BIT];
                    paddr_next = sh_shift[9:0];
                end
                if (cnt_reg == `PMT_FRAME_BITS - 5'h01) begin
                    wr_next = ~rd_reg;
                    oe_next = 1'b0;
                end
            end
            if (fall && rd_reg && cnt_reg >= `PMT_HDR_BITS && cnt_reg < `PMT_FRAME_BITS) begin
                dout_next = out_reg[13];
                out_next = {out_reg[12:0], 1'b0};
                oe_next = 1'b1;
            end
            if (load_reg) begin
                out_next = rd_data_reg;
            end
        end
        load_next = rd_start;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 5'h00;
            sh_reg <= 25'h0000000;
            paddr_reg <= 10'h000;
            out_reg <= 14'h0000;
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            paddr_reg <= paddr_next;
            out_reg <= out_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            load_reg <= load_next;
        end
    end

    // Fetch and table read share the single read port
    assign stall = en || (src_reg == PMT_SRC_TAB);
    assign take_tab = bus.tab_req && !stall;

    always_comb begin
        pc_next = pc_reg;
        rd_addr = pc_reg;
        src_next = PMT_SRC_PC;
        dest_next = dest_reg;
        if (rd_start) begin
            rd_addr = sh_shift[9:0];
            src_next = PMT_SRC_PROG;
        end else if (en) begin
            src_next = PMT_SRC_NONE;
        end else if (take_tab) begin
            rd_addr = tab_addr(bus.tab_last, ptr_hi_reg, ptr_lo_reg);
            src_next = PMT_SRC_TAB;
            dest_next = bus.tab_dest;
        end else if (!stall && bus.jump) begin
            pc_next = bus.jump_addr;
            rd_addr = bus.jump_addr;
        end else if (!stall && bus.fetch_next) begin
            pc_next = pc_reg + 10'h001;
            rd_addr = pc_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pc_reg <= `PMT_RESET_VEC;
            src_reg <= PMT_SRC_NONE;
            dest_reg <= 8'h00;
            rd_data_reg <= 14'h0000;
        end else begin
            pc_reg <= pc_next;
            src_reg <= src_next;
            dest_reg <= dest_next;
            rd_data_reg <= mem[rd_addr];
        end
        if (wr_reg) begin
            mem[sh_reg[23:14]] <= sh_reg[13:0];
        end
    end

    // Table pointer and table-high latch
    always_comb begin
        ptr_lo_next = ptr_lo_reg;
        ptr_hi_next = ptr_hi_reg;
        latch_next = latch_reg;
        if (bus.sfr_wr && bus.sfr_sel == PMT_SFR_PTR_LO) begin
            ptr_lo_next = bus.sfr_wdata;
        end
        if (bus.sfr_wr && bus.sfr_sel == PMT_SFR_PTR_HI) begin
            ptr_hi_next = bus.sfr_wdata[1:0];
        end
        if (src_reg == PMT_SRC_TAB) begin
            latch_next = {`PMT_LATCH_PAD, rd_data_reg[13:`PMT_LATCH_LSB]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ptr_lo_reg <= `PMT_PTR_LO_RST;
            ptr_hi_reg <= `PMT_PTR_HI_RST;
            latch_reg <= `PMT_LATCH_RST;
        end else begin
            ptr_lo_reg <= ptr_lo_next;
            ptr_hi_reg <= ptr_hi_next;
            latch_reg <= latch_next;
        end
    end

    // Outputs to the core end
    assign bus.instr = rd_data_reg;
    assign bus.instr_addr = pc_reg;
    assign bus.instr_valid = (src_reg == PMT_SRC_PC);
    assign bus.stall = stall;
    assign bus.tab_done = (src_reg == PMT_SRC_TAB);
    assign bus.tab_low = rd_data_reg[7:0];
    assign bus.tab_dest_out = dest_reg;
    assign bus.ptr_lo = ptr_lo_reg;
    assign bus.ptr_hi = {6'h00, ptr_hi_reg};
    assign bus.table_high_latch = latch_reg;
    assign bus.prog_dat_d = dout_reg;
    assign bus.prog_oe_d = oe_reg;

    // Debug pins: shared functions silenced in the emulation variant
    assign bus.dbg_dat_d = shared_dat_out_i;
    assign bus.dbg_oe_d = EMULATION ? 1'b0 : shared_dat_oe_i;
    assign shared_in_o = EMULATION ? 2'h0 : sync2_reg[4:3];
    assign prog_active_o = en;
endmodule

//--- shared/pmt_consts.svh
// Constants of the program memory table reader
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
`define PMT_ADDR_W 10
`define PMT_WORD_W 14
`define PMT_MEM_DEPTH 1024
`define PMT_RESET_VEC 10'h000
`define PMT_LAST_PAGE_BASE 10'h300
`define PMT_PTR_HI_W 2
`define PMT_LATCH_LSB 8
`define PMT_LATCH_PAD 2'h0
`define PMT_PTR_LO_RST 8'h00
`define PMT_PTR_HI_RST 2'h0
`define PMT_LATCH_RST 8'h00
`define PMT_FRAME_BITS 5'h19
`define PMT_HDR_BITS 5'h0b
`define PMT_CMD_BIT 10
`define PMT_PROG_HALF_CYC 8
`endif

//--- shared/pmt_if.sv
// Interface joining the code store end and the core end
`timescale 1ns/100ps
interface pmt_if;
    import pmt_pkg::*;
    logic fetch_next;
    logic jump;
    logic [9:0] jump_addr;
    logic [13:0] instr;
    logic [9:0] instr_addr;
    logic instr_valid;
    logic stall;
    logic tab_req;
    logic tab_last;
    logic [7:0] tab_dest;
    logic tab_done;
    logic [7:0] tab_low;
    logic [7:0] tab_dest_out;
    logic sfr_wr;
    pmt_sfr_sel_t sfr_sel;
    logic [7:0] sfr_wdata;
    logic [7:0] ptr_lo;
    logic [7:0] ptr_hi;
    logic [7:0] table_high_latch;
    logic prog_en;
    logic prog_serial_clock;
    logic prog_dat_h;
    logic prog_oe_h;
    logic prog_dat_d;
    logic prog_oe_d;
    logic debug_serial_clock;
    logic dbg_dat_h;
    logic dbg_oe_h;
    logic dbg_dat_d;
    logic dbg_oe_d;
    logic prog_serial_data;
    logic debug_serial_data;
    // Wire levels with pull-up when nobody drives
    assign prog_serial_data = prog_oe_h ? prog_dat_h : (prog_oe_d ? prog_dat_d : 1'b1);
    assign debug_serial_data = dbg_oe_h ? dbg_dat_h : (dbg_oe_d ? dbg_dat_d : 1'b1);
    modport dev (
        input fetch_next, jump, jump_addr, tab_req, tab_last, tab_dest,
        input sfr_wr, sfr_sel, sfr_wdata,
        input prog_en, prog_serial_clock, prog_serial_data,
        input debug_serial_clock, debug_serial_data,
        output instr, instr_addr, instr_valid, stall, tab_done, tab_low, tab_dest_out,
        output ptr_lo, ptr_hi, table_high_latch, prog_dat_d, prog_oe_d, dbg_dat_d, dbg_oe_d
    );
    modport cpu (
        output fetch_next, jump, jump_addr, tab_req, tab_last, tab_dest,
        output sfr_wr, sfr_sel, sfr_wdata,
        output prog_en, prog_serial_clock, prog_dat_h, prog_oe_h,
        output debug_serial_clock, dbg_dat_h, dbg_oe_h,
        input prog_serial_data, debug_serial_data,
        input instr, instr_addr, instr_valid, stall, tab_done, tab_low, tab_dest_out,
        input ptr_lo, ptr_hi, table_high_latch
    );
endinterface

//--- shared/pmt_pkg.sv
// Types of the program memory table reader
package pmt_pkg;
    typedef enum logic [1:0] {
        PMT_SFR_PTR_LO,
        PMT_SFR_PTR_HI,
        PMT_SFR_LATCH
    } pmt_sfr_sel_t;
    typedef enum logic [1:0] {
        PMT_SRC_NONE,
        PMT_SRC_PC,
        PMT_SRC_TAB,
        PMT_SRC_PROG
    } pmt_src_t;
    typedef enum logic [1:0] {
        PMT_PG_IDLE,
        PMT_PG_LOW,
        PMT_PG_HIGH,
        PMT_PG_GAP
    } pmt_pg_state_t;
endpackage

//--- tb/pmt_asserts.sv
// Assertions on the link between the code store end and the core end
`timescale 1ns/100ps
module pmt_asserts
    import pmt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Fetch
    input wire logic jump,
    input wire logic [9:0] jump_addr,
    input wire logic [9:0] instr_addr,
    input wire logic instr_valid,
    input wire logic stall,
    // Table read
    input wire logic tab_req,
    input wire logic [7:0] tab_dest,
    input wire logic tab_done,
    input wire logic [7:0] tab_dest_out,
    input wire logic [7:0] table_high_latch,
    // Special registers
    input wire logic sfr_wr,
    input wire pmt_sfr_sel_t sfr_sel,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] ptr_lo,
    input wire logic [7:0] ptr_hi,
    // Programming pins
    input wire logic prog_en,
    input wire logic prog_oe_h,
    input wire logic prog_oe_d
);
    default clocking dck @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Table request accepted
    sequence s_tab_take;
        tab_req && !stall && !prog_en;
    endsequence
    // Answer cycle then free again
    sequence s_tab_answer;
        tab_done && stall ##1 !stall;
    endsequence
    AST_RESET_VEC: assert property (disable iff (1'b0)
        !reset_n_i ##1 reset_n_i |-> instr_addr == 10'h000) else $error("fetch not at reset entry");
    AST_JUMP_PC: assert property (jump && !stall && !tab_req |=>
        instr_valid && instr_addr == $past(jump_addr)) else $error("jump address not fetched");
    AST_TAB_TWO_CYC: assert property (s_tab_take |=> s_tab_answer)
        else $error("table read not two cycles");
    AST_TAB_DONE_PULSE: assert property (tab_done |=> !tab_done)
        else $error("table done longer than one cycle");
    AST_TAB_DEST: assert property (s_tab_take |=> tab_dest_out == $past(tab_dest))
        else $error("table destination lost");
    AST_LATCH_HOLD: assert property (!tab_done |=> $stable(table_high_latch))
        else $error("latch changed without table read");
    AST_LATCH_PAD: assert property (table_high_latch[7:6] == 2'b00)
        else $error("latch pad bits not zero");
    AST_PTR_LO_WR: assert property (sfr_wr && sfr_sel == PMT_SFR_PTR_LO |=>
        ptr_lo == $past(sfr_wdata)) else $error("pointer low not written");
    AST_PTR_HI_WR: assert property (sfr_wr && sfr_sel == PMT_SFR_PTR_HI |=>
        ptr_hi == ($past(sfr_wdata) & 8'h03)) else $error("pointer high wrong");
    AST_ONE_DRIVER: assert property (!(prog_oe_h && prog_oe_d))
        else $error("both ends drive programming data");
endmodule

//--- tb/program_memory_table_reader_tb.sv
// Testbench joining both ends of the program memory table reader
`timescale 1ns/100ps
module program_memory_table_reader_tb
    import pmt_pkg::*;
;
    localparam logic [13:0] W000 = 14'h1234;
    localparam logic [13:0] W105 = 14'h0bcd;
    localparam logic [13:0] W305 = 14'h3f0f;
    localparam logic [13:0] W306 = 14'h001a;
    int n_errors = 0;
    int n_tests = 0;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0;
    logic usr_fetch_next_i = 1'b0, usr_jump_i = 1'b0, usr_tab_req_i = 1'b0, usr_tab_last_i = 1'b0;
    logic usr_in_isr_i = 1'b0, usr_irq_req_i = 1'b0, usr_sfr_wr_i = 1'b0, usr_prog_start_i = 1'b0;
    logic usr_prog_write_i = 1'b0, usr_dbg_clk_i = 1'b0, usr_dbg_dat_i = 1'b0, usr_dbg_oe_i = 1'b0;
    logic shared_dat_out_i = 1'b0, shared_dat_oe_i = 1'b0;
    logic [9:0] usr_jump_addr_i = 10'h000, usr_prog_addr_i = 10'h000;
    logic [7:0] usr_tab_dest_i = 8'h00, usr_sfr_wdata_i = 8'h00;
    logic [13:0] usr_prog_data_i = 14'h0000;
    pmt_sfr_sel_t usr_sfr_sel_i = PMT_SFR_PTR_LO;
    logic usr_instr_valid_o, usr_stall_o, usr_irq_take_o, usr_tab_done_o, usr_prog_busy_o;
    logic usr_prog_done_o, usr_dbg_dat_o, prog_active_o;
    logic [1:0] shared_in_o;
    logic [9:0] usr_instr_addr_o;
    logic [13:0] usr_instr_o, usr_prog_rdata_o;
    logic [7:0] usr_tab_low_o, usr_tab_dest_o, usr_ptr_lo_o, usr_ptr_hi_o, usr_table_high_o;

    pmt_if bus_if();
    pmt_dev_end pmt_dev_end_inst (.bus(bus_if), .*);
    pmt_cpu_end #(.PROG_HALF(8)) pmt_cpu_end_inst (.bus(bus_if), .*);
    pmt_asserts pmt_asserts_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .jump(bus_if.jump),
        .jump_addr(bus_if.jump_addr), .instr_addr(bus_if.instr_addr),
        .instr_valid(bus_if.instr_valid), .stall(bus_if.stall), .tab_req(bus_if.tab_req),
        .tab_dest(bus_if.tab_dest), .tab_done(bus_if.tab_done),
        .tab_dest_out(bus_if.tab_dest_out), .table_high_latch(bus_if.table_high_latch),
        .sfr_wr(bus_if.sfr_wr), .sfr_sel(bus_if.sfr_sel), .sfr_wdata(bus_if.sfr_wdata),
        .ptr_lo(bus_if.ptr_lo), .ptr_hi(bus_if.ptr_hi), .prog_en(bus_if.prog_en),
        .prog_oe_h(bus_if.prog_oe_h), .prog_oe_d(bus_if.prog_oe_d)
    );

    always #10 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic prog(input logic wr, input logic [9:0] a, input logic [13:0] d);
        int n;
        @(negedge clk_sys_i);
        usr_prog_start_i = 1'b1;
        usr_prog_write_i = wr;
        usr_prog_addr_i = a;
        usr_prog_data_i = d;
        @(negedge clk_sys_i);
        usr_prog_start_i = 1'b0;
        check(usr_prog_busy_o, 1'b1);
        repeat (3) @(negedge clk_sys_i);
        check(prog_active_o, 1'b1);
        check(usr_stall_o, 1'b1);
        for (n = 0; n < 1000 && usr_prog_done_o !== 1'b1; n++) begin
            @(negedge clk_sys_i);
        end
        check(usr_prog_done_o, 1'b1);
        if (!wr) begin
            check(usr_prog_rdata_o, d);
        end
    endtask

    task automatic wait_instr(input logic [9:0] a, input logic [13:0] w);
        int n;
        for (n = 0; n < 8 && !(usr_instr_valid_o === 1'b1 && usr_instr_addr_o === a); n++) begin
            @(negedge clk_sys_i);
        end
        check(usr_instr_addr_o, a);
        check(usr_instr_o, w);
    endtask

    task automatic sfr(input pmt_sfr_sel_t sel, input logic [7:0] d);
        @(negedge clk_sys_i);
        usr_sfr_wr_i = 1'b1;
        usr_sfr_sel_i = sel;
        usr_sfr_wdata_i = d;
        @(negedge clk_sys_i);
        usr_sfr_wr_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
    endtask

    task automatic tab_read(input logic last, input logic [7:0] dest, input logic [13:0] w,
                            input logic gate);
        int n;
        logic low_seen;
        @(negedge clk_sys_i);
        usr_tab_req_i = 1'b1;
        usr_tab_last_i = last;
        usr_tab_dest_i = dest;
        @(negedge clk_sys_i);
        usr_tab_req_i = 1'b0;
        low_seen = (usr_irq_take_o === 1'b0);
        for (n = 0; n < 8 && usr_tab_done_o !== 1'b1; n++) begin
            @(negedge clk_sys_i);
            low_seen = low_seen | (usr_irq_take_o === 1'b0);
        end
        check(usr_tab_low_o, w[7:0]);
        check(usr_tab_dest_o, dest);
        check(usr_stall_o, 1'b1);
        @(negedge clk_sys_i);
        check(usr_tab_done_o, 1'b0);
        repeat (2) @(negedge clk_sys_i);
        check(usr_table_high_o, {2'b00, w[13:8]});
        check(low_seen, gate);
    endtask

    task automatic load_store();
        prog(1'b1, 10'h000, W000);
        prog(1'b1, 10'h105, W105);
        prog(1'b1, 10'h305, W305);
        prog(1'b1, 10'h306, W306);
        prog(1'b0, 10'h305, W305);
        check(bus_if.prog_serial_data, 1'b1);
    endtask

    task automatic reset_and_fetch();
        @(negedge clk_sys_i);
        reset_n_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        wait_instr(10'h000, W000);
        usr_jump_addr_i = 10'h305;
        usr_jump_i = 1'b1;
        @(negedge clk_sys_i);
        usr_jump_i = 1'b0;
        wait_instr(10'h305, W305);
        usr_fetch_next_i = 1'b1;
        @(negedge clk_sys_i);
        usr_fetch_next_i = 1'b0;
        wait_instr(10'h306, W306);
    endtask

    task automatic table_reads();
        usr_irq_req_i = 1'b1;
        usr_in_isr_i = 1'b1;
        sfr(PMT_SFR_PTR_LO, 8'h06);
        sfr(PMT_SFR_PTR_HI, 8'hff);
        check(usr_ptr_hi_o, 8'h03);
        check(usr_ptr_lo_o, 8'h06);
        tab_read(1'b0, 8'h40, W306, 1'b0);
        usr_in_isr_i = 1'b0;
        sfr(PMT_SFR_PTR_LO, 8'h05);
        tab_read(1'b0, 8'h41, W305, 1'b1);
        sfr(PMT_SFR_PTR_HI, 8'h01);
        tab_read(1'b0, 8'h42, W105, 1'b1);
        tab_read(1'b1, 8'h43, W305, 1'b1);
        check(usr_irq_take_o, 1'b1);
        sfr(PMT_SFR_LATCH, 8'hff);
        check(usr_table_high_o, {2'b00, W305[13:8]});
        usr_irq_req_i = 1'b0;
    endtask

    task automatic debug_pins();
        shared_dat_oe_i = 1'b1;
        usr_dbg_clk_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check(usr_dbg_dat_o, 1'b1);
        check(shared_in_o, 2'b00);
        usr_dbg_oe_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check(usr_dbg_dat_o, 1'b0);
        check(bus_if.debug_serial_data, 1'b0);
        usr_dbg_oe_i = 1'b0;
        shared_dat_oe_i = 1'b0;
    endtask

    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        load_store();
        reset_and_fetch();
        table_reads();
        debug_pins();
        print_verdict();
    end
endmodule
